// ===== rtl/ard_defines.svh
// constants for the round datapath: field polynomial, affine constants, coefficients
`ifndef ARD_DEFINES_SVH
`define ARD_DEFINES_SVH

// reduction term of x^8 + x^4 + x^3 + x + 1 once x^8 is dropped
`define ARD_FIELD_POLY 8'h1b
// affine constants of the forward and inverse substitution
`define ARD_AFFINE_FWD 8'h63
`define ARD_AFFINE_INV 8'h05
// column mixing coefficients, row 0 order
`define ARD_MIX_C0 8'h02
`define ARD_MIX_C1 8'h03
`define ARD_MIX_C2 8'h01
`define ARD_MIX_C3 8'h01
// inverse column mixing coefficients, row 0 order
`define ARD_IMIX_C0 8'h0e
`define ARD_IMIX_C1 8'h0b
`define ARD_IMIX_C2 8'h0d
`define ARD_IMIX_C3 8'h09
// reset values of the result port
`define ARD_RESULT_RESET 128'h0
`define ARD_VALID_RESET 1'b0
// cycles from request to result
`define ARD_LATENCY 1

`endif

// ===== rtl/ard_pkg.sv
// types and field arithmetic shared by the round datapath files
`include "ard_defines.svh"

package ard_pkg;

  typedef logic [7:0] ard_byte_t;
  typedef logic [31:0] ard_word_t;
  typedef logic [127:0] ard_block_t;

  // operation codes of the request port
  typedef enum logic [2:0] {
    ARD_ENCRYPT_ROUND_OP       = 3'b000,
    ARD_ENCRYPT_FINAL_ROUND_OP = 3'b001,
    ARD_DECRYPT_ROUND_OP       = 3'b010,
    ARD_DECRYPT_FINAL_ROUND_OP = 3'b011,
    ARD_INVERSE_COLUMN_MIX_OP  = 3'b100,
    ARD_ROUND_KEY_ASSIST_OP    = 3'b101
  } ard_op_t;

  // carry-less product reduced by the field polynomial
  function automatic ard_byte_t field_multiply(input ard_byte_t a, input ard_byte_t b);
    ard_byte_t p;
    ard_byte_t x;
    p = 8'h00;
    x = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) begin
        p = p ^ x;
      end
      x = {x[6:0], 1'b0} ^ (x[7] ? `ARD_FIELD_POLY : 8'h00);
    end
    return p;
  endfunction

  // one column through the forward or inverse mixing matrix, row 0 in the low byte
  function automatic ard_word_t column_mixing(input ard_word_t w, input logic inv);
    ard_word_t o;
    ard_byte_t c [4];
    c[0] = inv ? `ARD_IMIX_C0 : `ARD_MIX_C0;
    c[1] = inv ? `ARD_IMIX_C1 : `ARD_MIX_C1;
    c[2] = inv ? `ARD_IMIX_C2 : `ARD_MIX_C2;
    c[3] = inv ? `ARD_IMIX_C3 : `ARD_MIX_C3;
    o = 32'h0;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        o[8*i +: 8] = o[8*i +: 8] ^ field_multiply(c[k], w[8*((i+k)%4) +: 8]);
      end
    end
    return o;
  endfunction

  // whole state through column mixing, one word per column
  function automatic ard_block_t state_mixing(input ard_block_t s, input logic inv);
    ard_block_t o;
    o = 128'h0;
    for (int j = 0; j < 4; j++) begin
      o[32*j +: 32] = column_mixing(s[32*j +: 32], inv);
    end
    return o;
  endfunction

  // row r rotates left by r byte positions, or right when inverse
  function automatic ard_block_t row_shifting(input ard_block_t s, input logic inv);
    ard_block_t o;
    int src;
    o = 128'h0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? (c - r + 4) % 4 : (c + r) % 4;
        o[8*(4*c+r) +: 8] = s[8*(4*src+r) +: 8];
      end
    end
    return o;
  endfunction

endpackage

// ===== rtl/ard_round_datapath.sv
// single-cycle round datapath for the block cipher on 128-bit states
//
// Summary of operation
// - encrypt round and final round on state plus key
// - decrypt rounds use equivalent inverse cipher order
// - standalone inverse column mixing on a state
// - key schedule assist: substitute, rotate, add constant
// - state from register, key from register or memory
// - state is four words, word 0 lowest
// - matrix byte (i,j) sits at byte 4j+i
// - printed vectors are byte-reversed against this layout
// - column mixing uses fixed 02 03 01 01 matrix
// - rows 1 to 3 rotate left by row number
// - every byte passes the substitution table, except in standalone inverse column mixing
// - field products reduced by x^8+x^4+x^3+x+1
`timescale 1ns/1ps

`include "ard_defines.svh"

module ard_round_datapath (
  input wire logic core_clk,                      // pipeline clock
  input wire logic arst_n,                        // async reset, active low
  input wire logic req_valid,                     // request strobe, one cycle
  input wire ard_pkg::ard_op_t req_op,            // operation code
  input wire ard_pkg::ard_block_t req_state,      // state operand
  input wire ard_pkg::ard_block_t req_key_reg,    // round key from a vector register
  input wire ard_pkg::ard_block_t req_key_mem,    // round key from a memory operand
  input wire logic req_key_from_mem,              // high selects the memory key
  input wire ard_pkg::ard_byte_t req_rcon,        // round constant for key assist
  output ard_pkg::ard_block_t res_data,           // result, held until next request
  output logic res_valid                          // result strobe, one cycle
);

  // ------------------------------------------------------------------
  // operand selection and substitution
  // ------------------------------------------------------------------

  ard_pkg::ard_block_t round_key;
  // a net, because sixteen table instances each drive their own byte of it
  wire ard_pkg::ard_block_t sub_state;
  logic inv_dir;

  // the key source is decided by the caller; both paths are equal width
  assign round_key = req_key_from_mem ? req_key_mem : req_key_reg;

  // decrypt operations use the inverse table and inverse row order
  assign inv_dir = (req_op == ard_pkg::ARD_DECRYPT_ROUND_OP) ||
                   (req_op == ard_pkg::ARD_DECRYPT_FINAL_ROUND_OP);

  // substitution is bytewise so it commutes with row shifting; doing it first
  // lets key assist share the same sixteen table circuits
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : g_sub
      ard_sbox u_sbox (
        .in_byte(req_state[8*b +: 8]),
        .inverse(inv_dir),
        .out_byte(sub_state[8*b +: 8])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // round arithmetic
  // ------------------------------------------------------------------

  ard_pkg::ard_block_t shifted;
  ard_pkg::ard_block_t op_result;
  ard_pkg::ard_word_t sub_w1;
  ard_pkg::ard_word_t sub_w3;

  assign shifted = ard_pkg::row_shifting(sub_state, inv_dir);
  assign sub_w1 = sub_state[63:32];
  assign sub_w3 = sub_state[127:96];

  // per operation result; key is xored after everything else
  always_comb begin
    case (req_op)
      ard_pkg::ARD_ENCRYPT_ROUND_OP: begin
        op_result = ard_pkg::state_mixing(shifted, 1'b0) ^ round_key;
      end
      ard_pkg::ARD_ENCRYPT_FINAL_ROUND_OP: begin
        op_result = shifted ^ round_key;
      end
      ard_pkg::ARD_DECRYPT_ROUND_OP: begin
        op_result = ard_pkg::state_mixing(shifted, 1'b1) ^ round_key;
      end
      ard_pkg::ARD_DECRYPT_FINAL_ROUND_OP: begin
        op_result = shifted ^ round_key;
      end
      ard_pkg::ARD_INVERSE_COLUMN_MIX_OP: begin
        op_result = ard_pkg::state_mixing(req_state, 1'b1);
      end
      ard_pkg::ARD_ROUND_KEY_ASSIST_OP: begin
        // rotate right in little-endian byte order, constant into the low byte
        op_result = {{sub_w3[7:0], sub_w3[31:8]} ^ {24'h0, req_rcon}, sub_w3,
                     {sub_w1[7:0], sub_w1[31:8]} ^ {24'h0, req_rcon}, sub_w1};
      end
      default: begin
        op_result = `ARD_RESULT_RESET; // undefined codes give an all-zero result
      end
    endcase
  end

  // ------------------------------------------------------------------
  // result register
  // ------------------------------------------------------------------

  ard_pkg::ard_block_t next_res_data;
  logic next_res_valid;

  // result holds between requests so a slow consumer may sample late
  always_comb begin
    next_res_valid = req_valid;
    next_res_data = req_valid ? op_result : res_data;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_valid <= `ARD_VALID_RESET;
      res_data <= `ARD_RESULT_RESET;
    end else begin
      res_valid <= next_res_valid;
      res_data <= next_res_data;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  // copies of the request for the checks only
  ard_pkg::ard_op_t op_q;
  ard_pkg::ard_block_t key_q;
  ard_pkg::ard_block_t state_q;
  ard_pkg::ard_block_t sub_q;
  ard_pkg::ard_byte_t rcon_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q <= ard_pkg::ARD_ENCRYPT_ROUND_OP;
      key_q <= 128'h0;
      state_q <= 128'h0;
      sub_q <= 128'h0;
      rcon_q <= 8'h00;
    end else begin
      op_q <= req_op;
      key_q <= round_key;
      state_q <= req_state;
      sub_q <= sub_state;
      rcon_q <= req_rcon;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_req;
    req_valid;
  endsequence

  sequence s_answer;
    res_valid ##1 (!res_valid || $past(req_valid));
  endsequence

  chk_res_latency: assert property (s_req |=> s_answer)
    else $error("result strobe did not follow request by one cycle");

  chk_no_spurious: assert property (!req_valid |=> !res_valid && $stable(res_data))
    else $error("result moved without a request");

  // rounds are judged by undoing the mixing instead of redoing it, so a fault
  // in the forward path is not simply repeated by the check
  chk_enc_round: assert property (res_valid
      && op_q == ard_pkg::ARD_ENCRYPT_ROUND_OP
      |-> ard_pkg::state_mixing(res_data ^ key_q, 1'b1) ==
          ard_pkg::row_shifting(sub_q, 1'b0))
    else $error("encrypt round does not invert to shifted substitution");

  chk_enc_final: assert property (res_valid
      && op_q == ard_pkg::ARD_ENCRYPT_FINAL_ROUND_OP
      |-> (res_data ^ key_q) == ard_pkg::row_shifting(sub_q, 1'b0))
    else $error("encrypt final round mixed columns or lost the key");

  chk_dec_round: assert property (res_valid
      && op_q == ard_pkg::ARD_DECRYPT_ROUND_OP
      |-> ard_pkg::state_mixing(res_data ^ key_q, 1'b0) ==
          ard_pkg::row_shifting(sub_q, 1'b1))
    else $error("decrypt round not in equivalent inverse order");

  chk_dec_final: assert property (res_valid
      && op_q == ard_pkg::ARD_DECRYPT_FINAL_ROUND_OP
      |-> (res_data ^ key_q) == ard_pkg::row_shifting(sub_q, 1'b1))
    else $error("decrypt final round mixed columns or lost the key");

  chk_imc_inverse: assert property (res_valid
      && op_q == ard_pkg::ARD_INVERSE_COLUMN_MIX_OP
      |-> ard_pkg::state_mixing(res_data, 1'b0) == state_q)
    else $error("inverse column mix does not undo forward mixing");

  chk_key_assist: assert property (res_valid
      && op_q == ard_pkg::ARD_ROUND_KEY_ASSIST_OP
      |-> res_data[31:0] == sub_q[63:32] && res_data[95:64] == sub_q[127:96] &&
          res_data[63:32] == ({sub_q[39:32], sub_q[63:40]} ^ {24'h0, rcon_q}) &&
          res_data[127:96] == ({sub_q[103:96], sub_q[127:104]} ^ {24'h0, rcon_q}))
    else $error("key assist words wrong");

  // row 0 never moves, so its bytes are the substituted input plus the key
  chk_row_zero_enc: assert property (res_valid
      && op_q == ard_pkg::ARD_ENCRYPT_FINAL_ROUND_OP
      |-> {res_data[103:96], res_data[71:64], res_data[39:32], res_data[7:0]} ==
          ({key_q[103:96], key_q[71:64], key_q[39:32], key_q[7:0]} ^
           {sub_q[103:96], sub_q[71:64], sub_q[39:32], sub_q[7:0]}))
    else $error("row zero moved in an encrypt final round");

  chk_row_zero_dec: assert property (res_valid
      && op_q == ard_pkg::ARD_DECRYPT_FINAL_ROUND_OP
      |-> {res_data[103:96], res_data[71:64], res_data[39:32], res_data[7:0]} ==
          ({key_q[103:96], key_q[71:64], key_q[39:32], key_q[7:0]} ^
           {sub_q[103:96], sub_q[71:64], sub_q[39:32], sub_q[7:0]}))
    else $error("row zero moved in a decrypt final round");

  chk_sbox_zero: assert property (req_valid && !inv_dir
      && req_state[7:0] == 8'h00
      |=> sub_q[7:0] == `ARD_AFFINE_FWD)
    else $error("forward substitution of zero is wrong");

  chk_field_mul: assert property (res_valid
      |-> ard_pkg::field_multiply(8'h57, 8'h83) == 8'hc1)
    else $error("field product does not reduce by the polynomial");

endmodule

// ===== rtl/ard_sbox.sv
// one byte through the forward or inverse substitution table
`timescale 1ns/1ps

`include "ard_defines.svh"

module ard_sbox (
  input wire ard_pkg::ard_byte_t in_byte, // byte to substitute
  input wire logic inverse,               // high for the inverse table
  output ard_pkg::ard_byte_t out_byte     // substituted byte
);

  // x^254 is the field inverse; zero maps to zero as the table expects
  function automatic ard_pkg::ard_byte_t field_inverse(input ard_pkg::ard_byte_t x);
    ard_pkg::ard_byte_t x2;
    ard_pkg::ard_byte_t x3;
    ard_pkg::ard_byte_t x12;
    ard_pkg::ard_byte_t x15;
    ard_pkg::ard_byte_t y;
    x2 = ard_pkg::field_multiply(x, x);
    x3 = ard_pkg::field_multiply(x2, x);
    x12 = ard_pkg::field_multiply(x3, x3);
    x12 = ard_pkg::field_multiply(x12, x12);
    x15 = ard_pkg::field_multiply(x12, x3);
    y = x15;
    for (int k = 0; k < 4; k++) begin
      y = ard_pkg::field_multiply(y, y);
    end
    y = ard_pkg::field_multiply(y, x12);
    return ard_pkg::field_multiply(y, x2);
  endfunction

  function automatic ard_pkg::ard_byte_t affine_fwd(input ard_pkg::ard_byte_t x);
    ard_pkg::ard_byte_t o;
    ard_pkg::ard_byte_t c;
    c = `ARD_AFFINE_FWD;
    for (int i = 0; i < 8; i++) begin
      o[i] = x[i] ^ x[(i+4)%8] ^ x[(i+5)%8] ^ x[(i+6)%8] ^ x[(i+7)%8] ^ c[i];
    end
    return o;
  endfunction

  function automatic ard_pkg::ard_byte_t affine_inv(input ard_pkg::ard_byte_t x);
    ard_pkg::ard_byte_t o;
    ard_pkg::ard_byte_t c;
    c = `ARD_AFFINE_INV;
    for (int i = 0; i < 8; i++) begin
      o[i] = x[(i+2)%8] ^ x[(i+5)%8] ^ x[(i+7)%8] ^ c[i];
    end
    return o;
  endfunction

  // computed rather than tabled: one circuit serves both directions
  assign out_byte = inverse ? field_inverse(affine_inv(in_byte))
                            : affine_fwd(field_inverse(in_byte));

endmodule

// ===== tb/ard_pipe_model.sv
// pipeline stage model that hands operands to the round datapath
`timescale 1ns/1ps

module ard_pipe_model (
  input wire logic core_clk,              // pipeline clock
  output logic req_valid,                 // request strobe
  output ard_pkg::ard_op_t req_op,        // operation code
  output ard_pkg::ard_block_t req_state,  // state operand
  output ard_pkg::ard_block_t req_key_reg, // key from a vector register
  output ard_pkg::ard_block_t req_key_mem, // key from memory
  output logic req_key_from_mem,          // key source select
  output ard_pkg::ard_byte_t req_rcon     // round constant
);
  // quiet from time zero so nothing is taken during reset
  initial begin
    req_valid = 1'b0;
    req_op = ard_pkg::ard_op_t'(3'h0);
    req_state = 128'h0;
    req_key_reg = 128'h0;
    req_key_mem = 128'h0;
    req_key_from_mem = 1'b0;
    req_rcon = 8'h00;
  end

  // one request; the strobe stays up so calls can follow back to back
  task automatic send(input ard_pkg::ard_op_t op, input ard_pkg::ard_block_t s, k, km,
                      input logic mem, input ard_pkg::ard_byte_t rc);
    req_valid = 1'b1;
    req_op = op;
    req_state = s;
    req_key_reg = k;
    req_key_mem = km;
    req_key_from_mem = mem;
    req_rcon = rc;
    @(posedge core_clk);
    #1;
  endtask

  // released operands flip so a stale value can never pass for a live one
  task automatic idle();
    req_valid = 1'b0;
    req_state = ~req_state;
    req_key_reg = ~req_key_reg;
    req_key_mem = ~req_key_mem;
    req_rcon = ~req_rcon;
    @(posedge core_clk);
    #1;
  endtask
endmodule

// ===== tb/tb_ard_round_datapath.sv
// self-checking bench for the round datapath driven through the pipeline model
`timescale 1ns/1ps

`include "ard_defines.svh"

module tb_ard_round_datapath;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid;
  ard_pkg::ard_op_t req_op;
  ard_pkg::ard_block_t req_state;
  ard_pkg::ard_block_t req_key_reg;
  ard_pkg::ard_block_t req_key_mem;
  logic req_key_from_mem;
  ard_pkg::ard_byte_t req_rcon;
  ard_pkg::ard_block_t res_data;
  logic res_valid;
  int err_count = 0;
  int cmp_count = 0;
  ard_pkg::ard_byte_t sb [256];
  ard_pkg::ard_byte_t isb [256];

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  ard_pipe_model pm (.core_clk(core_clk), .req_valid(req_valid), .req_op(req_op),
    .req_state(req_state), .req_key_reg(req_key_reg), .req_key_mem(req_key_mem),
    .req_key_from_mem(req_key_from_mem), .req_rcon(req_rcon));

  ard_round_datapath uut (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_op(req_op), .req_state(req_state), .req_key_reg(req_key_reg),
    .req_key_mem(req_key_mem), .req_key_from_mem(req_key_from_mem),
    .req_rcon(req_rcon), .res_data(res_data), .res_valid(res_valid));

  // ------------------------------------------------------------
  // reference model, kept apart from the design's own functions
  // ------------------------------------------------------------
  function automatic ard_pkg::ard_byte_t gm(input ard_pkg::ard_byte_t a, b);
    ard_pkg::ard_byte_t p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? `ARD_FIELD_POLY : 8'h00);
    end
    return p;
  endfunction

  function automatic ard_pkg::ard_block_t sub(input ard_pkg::ard_block_t s, input logic inv);
    for (int n = 0; n < 16; n++)
      s[8*n +: 8] = inv ? isb[s[8*n +: 8]] : sb[s[8*n +: 8]];
    return s;
  endfunction

  function automatic ard_pkg::ard_block_t shf(input ard_pkg::ard_block_t s, input logic inv);
    ard_pkg::ard_block_t o;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        o[32*c+8*r +: 8] = s[32*((inv ? c+4-r : c+r) % 4)+8*r +: 8];
    return o;
  endfunction

  function automatic ard_pkg::ard_block_t mix(input ard_pkg::ard_block_t s, input logic inv);
    ard_pkg::ard_byte_t c [4];
    ard_pkg::ard_block_t o;
    if (inv) c = '{8'h0e, 8'h0b, 8'h0d, 8'h09};
    else c = '{8'h02, 8'h03, 8'h01, 8'h01};
    o = 128'h0;
    for (int j = 0; j < 4; j++)
      for (int i = 0; i < 4; i++)
        for (int k = 0; k < 4; k++)
          o[32*j+8*i +: 8] ^= gm(c[k], s[32*j+8*((i+k)%4) +: 8]);
    return o;
  endfunction

  function automatic ard_pkg::ard_block_t model(input logic [2:0] op,
      input ard_pkg::ard_block_t s, k, input ard_pkg::ard_byte_t rc);
    ard_pkg::ard_block_t t;
    t = sub(s, op[1]);
    case (op)
      3'h0: return mix(shf(t, 1'b0), 1'b0) ^ k;
      3'h1: return shf(t, 1'b0) ^ k;
      3'h2: return mix(shf(t, 1'b1), 1'b1) ^ k;
      3'h3: return shf(t, 1'b1) ^ k;
      3'h4: return mix(s, 1'b1);
      3'h5: return {{t[103:96], t[127:104]} ^ {24'h0, rc}, t[127:96],
                    {t[39:32], t[63:40]} ^ {24'h0, rc}, t[63:32]};
      default: return 128'h0;
    endcase
  endfunction

  // printed text order puts the lowest byte first
  function automatic ard_pkg::ard_block_t rev(input ard_pkg::ard_block_t t);
    ard_pkg::ard_block_t o;
    for (int n = 0; n < 16; n++)
      o[8*n +: 8] = t[8*(15-n) +: 8];
    return o;
  endfunction

  // ------------------------------------------------------------
  // checking and scenarios
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [127:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // one request, judged just after the edge that takes it
  task automatic go(input logic [2:0] op, input ard_pkg::ard_block_t s, k, km,
                    input logic mem, input ard_pkg::ard_byte_t rc);
    pm.send(ard_pkg::ard_op_t'(op), s, k, km, mem, rc);
    check("res_valid", {127'h0, res_valid}, 128'h1);
    check("res_data", res_data, model(op, s, mem ? km : k, rc));
  endtask

  task automatic t_quiet(input logic [127:0] held);
    check("res_valid", {127'h0, res_valid}, 128'h0);
    check("res_data", res_data, held);
  endtask

  // known answers that lean on the substitution table alone, not on the model
  task automatic t_known();
    go(3'h1, 128'h01, 128'h0, 128'h0, 1'b0, 8'h00);
    check("final round of one", res_data, {{15{8'h63}}, 8'h7c});
    go(3'h3, {16{8'h63}}, 128'h0, 128'h0, 1'b0, 8'h00);
    check("inverse table", res_data, 128'h0);
  endtask

  // every code and both key sources, one request per cycle
  task automatic t_each_op();
    for (int m = 0; m < 2; m++)
      for (int o = 0; o < 8; o++)
        go(o[2:0], 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0 ^ {16{o[7:0]}},
           128'h5a5a_0001_c3c3_8000_1234_5678_9abc_def0, 128'h7e57_0bad_f00d_cafe_0102_0304_0506_0708,
           m[0], 8'h01 << o);
  endtask

  // result stands after the strobe drops
  task automatic t_hold();
    ard_pkg::ard_block_t e;
    e = model(3'h2, 128'h0123_4567_89ab_cdef_0011_2233_4455_6677, 128'h0, 8'h00);
    go(3'h2, 128'h0123_4567_89ab_cdef_0011_2233_4455_6677, 128'h0, 128'h1, 1'b0, 8'h00);
    pm.idle();
    t_quiet(e);
    pm.idle();
    t_quiet(e);
  endtask

  // a lone byte only disturbs its own column word
  task automatic t_byte_walk();
    for (int n = 0; n < 16; n++) begin
      go(3'h4, {120'h0, 8'h57} << (8*n), 128'h0, 128'h0, 1'b0, 8'h00);
      check("column", res_data & ~({96'h0, 32'hffff_ffff} << (32*(n/4))), 128'h0);
    end
  endtask

  // whole ciphers of each length, each round with its own key
  task automatic t_runs();
    ard_pkg::ard_block_t s;
    ard_pkg::ard_block_t k;
    int nr [3] = '{10, 12, 14};
    for (int v = 0; v < 3; v++) begin
      k = 128'h2b7e_1516_28ae_d2a6_abf7_1588_09cf_4f3c;
      s = rev(128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f) ^ k;
      for (int r = 1; r <= nr[v]; r++) begin
        k = {k[126:0], k[127]} ^ {120'h0, r[7:0]};
        go({2'b00, r == nr[v]}, s, k, ~k, 1'b0, 8'h00);
        s = model({2'b00, r == nr[v]}, s, k, 8'h00);
      end
    end
  endtask

  // reset in mid-run clears at once; first request right after release
  task automatic t_mid_reset();
    pm.send(ard_pkg::ard_op_t'(3'h0), 128'h1, 128'h2, 128'h3, 1'b1, 8'h00);
    arst_n = 1'b0;
    #1;
    t_quiet(128'h0);
    pm.idle();
    arst_n = 1'b1;
    go(3'h1, 128'h3, 128'h4, 128'h5, 1'b1, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // table built from field inverse plus affine step, then the sequence
  initial begin
    ard_pkg::ard_byte_t p;
    for (int x = 0; x < 256; x++) begin
      p = 8'h01;
      repeat (254) p = gm(p, x[7:0]);
      sb[x] = p ^ {p[6:0], p[7]} ^ {p[5:0], p[7:6]} ^ {p[4:0], p[7:5]} ^ {p[3:0], p[7:4]}
              ^ `ARD_AFFINE_FWD;
      isb[sb[x]] = x[7:0];
    end
    repeat (2) @(posedge core_clk);
    #1;
    t_quiet(128'h0);
    arst_n = 1'b1;
    t_each_op();
    t_known();
    t_hold();
    t_byte_walk();
    t_runs();
    t_mid_reset();
    tally_and_finish();
  end

  // the run needs under a hundred cycles; this cuts a hang well beyond that
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
